/* verif/ppmhc_host_model.sv */
// host model that services the event request
`timescale 1ns/100ps
`default_nettype none
module ppmhc_host_model
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic eventRequestN,
  input wire logic [3:0] interruptSummary,
  output logic portEventRead,
  output logic supplyEventRead
);
  logic [3:0] waitCnt_ff;
  // read summary, clear the source, then back off
  always_ff @(posedge ref_clk)
  begin
    portEventRead <= 1'b0;
    supplyEventRead <= 1'b0;
    if (!rst_n)
      waitCnt_ff <= 4'h0;
    else if (waitCnt_ff != 4'h0)
      waitCnt_ff <= waitCnt_ff - 4'h1;
    else if (!eventRequestN)
    begin
      portEventRead <= interruptSummary[0];
      supplyEventRead <= interruptSummary[1];
      waitCnt_ff <= slow ? 4'hC : 4'h3;
    end
  end
endmodule
`default_nettype wire

/* verif/ppmhc_top_props.sv */
// assertions on the port mode host control block
`timescale 1ns/100ps
`default_nettype none
module ppmhc_checker
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [3:0] portEventIn,
  input wire logic [3:0] eventMask,
  input wire logic portEventRead,
  input wire logic supplyEventRead,
  input wire logic portResetWrite,
  input wire logic [7:0] portResetCommand,
  input wire logic watchdogExpire,
  input wire logic eventRequestN,
  input wire logic [7:0] portModeOut,
  input wire logic [3:0] searchActive,
  input wire logic [3:0] autoRun,
  input wire logic [7:0] commandReadData
);
  // single clock domain, checks idle during reset
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_cmd_reads_zero: assert property (commandReadData == 8'h00)
    else $error("command read data not zero");
  a_event_req_low: assert property (
    |(portEventIn & ~eventMask) |-> ##2 !eventRequestN)
    else $error("event request not low after event");
  a_req_held_low: assert property (
    $rose(eventRequestN) |->
    $past(portEventRead, 2) || $past(supplyEventRead, 2))
    else $error("event request released without read");
  a_quad_shut: assert property (
    portResetWrite && portResetCommand[4] |-> ##2 portModeOut == 8'h00)
    else $error("quad reset left a port running");
  a_port_shut: assert property (
    portResetWrite && portResetCommand[0] |->
    ##2 portModeOut[1:0] == 2'h0)
    else $error("port reset bit ignored");
  a_wdog_shut: assert property (
    watchdogExpire |-> ##2 portModeOut == 8'h00)
    else $error("watchdog expiry left a port running");
  a_search_semi: assert property (
    searchActive[0] |-> portModeOut[1:0] == ppmhc_pkg::PPMHC_SEMI)
    else $error("search outside semi mode");
  a_auto_run: assert property (
    autoRun[0] |-> portModeOut[1:0] == ppmhc_pkg::PPMHC_AUTO)
    else $error("auto run outside auto mode");
endmodule
////////////////////////////////////////////////////////////////////////////
bind ppmhc_top ppmhc_checker ppmhc_checker_inst
(
  .ref_clk, .rst_n, .portEventIn, .eventMask, .portEventRead,
  .supplyEventRead, .portResetWrite, .portResetCommand, .watchdogExpire,
  .eventRequestN, .portModeOut, .searchActive, .autoRun, .commandReadData
);
`default_nettype wire

/* verif/tb.sv */
// testbench for the port mode host control block
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic ref_clk = 1'b0, rst_n = 1'b0, hardResetPinN = 1'b1, slow = 1'b0;
  logic modeWrite = 1'b0, probeEnableWrite = 1'b0, portResetWrite = 1'b0;
  logic powerOnWrite = 1'b0, portOrderMapWrite = 1'b0, watchdogExpire = 1'b0;
  logic commandRead = 1'b0, eventRequestN, portEventRead, supplyEventRead;
  logic [7:0] modeWriteData = 8'h00, probeEnableData = 8'h00, portOrderMap;
  logic [7:0] portResetCommand = 8'h00, portOrderMapData = 8'h00, portModeOut;
  logic [3:0] powerOnCommand = 4'h0, supplyEventIn = 4'h0, portEventIn = 4'h0;
  logic [3:0] eventMask = 4'h0, interruptSummary;
  logic autoStrapN = 1'b1, portOrderMapLocked;
  logic [3:0] searchActive, autoRun, forcePowerOn;
  logic [7:0] commandReadData;
  logic [31:0] seed = 32'h8CA1FC71;
  logic [15:0] expQ[$];
  logic [7:0] m;
  int n_errors = 0, n_compared = 0;
  event seen;
  ppmhc_top ppmhc_top_inst
  (
    .ref_clk, .rst_n, .hardResetPinN, .quadSelect(1'b0), .modeWriteData,
    .modeWrite, .probeEnableData, .probeEnableWrite, .portResetCommand,
    .portResetWrite, .powerOnCommand, .powerOnWrite, .portOrderMapData,
    .portOrderMapWrite, .autoStrapN, .supplyEventIn,
    .supplyConditionIn(4'h0), .watchdogExpire, .portEventIn, .eventMask,
    .portEventRead, .supplyEventRead, .commandRead, .eventRequestN,
    .portModeOut, .searchActive, .autoRun, .forcePowerOn,
    .portOrderMap, .portOrderMapLocked, .supplyEventOut(),
    .commandReadData, .interruptSummary
  );
  ppmhc_host_model ppmhc_host_model_inst
  (
    .ref_clk, .rst_n, .slow, .eventRequestN, .interruptSummary,
    .portEventRead, .supplyEventRead
  );
  ////////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;
  function logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // direct check of an output that stands now
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      $display("ERROR at %0t got %h exp %h", $time, g, e);
      n_errors++;
    end
  endtask
  task note(input logic [15:0] e);
    expQ.push_back(e);
    ->seen;
  endtask
  task setMode(input logic [7:0] d);
    modeWriteData = d;
    modeWrite = 1'b1;
    step(1);
    modeWrite = 1'b0;
    step(3);
  endtask
  task cmd(input logic [7:0] c);
    portResetCommand = c;
    portResetWrite = 1'b1;
    commandRead = 1'b1;
    step(1);
    chk(commandReadData, 8'h00);
    portResetWrite = 1'b0;
    commandRead = 1'b0;
    step(3);
  endtask
  task mapWr(input logic [7:0] d);
    portOrderMapData = d;
    portOrderMapWrite = 1'b1;
    step(1);
    portOrderMapWrite = 1'b0;
    step(3);
  endtask
  task give_verdict();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // compare oldest note with map and modes
  always @(seen)
  begin
    n_compared++;
    if ({portOrderMap, portModeOut} !== expQ[0])
      $display("ERROR at %0t got %h exp %h", $time,
        {portOrderMap, portModeOut}, expQ[0]);
    if ({portOrderMap, portModeOut} !== expQ[0])
      n_errors++;
    void'(expQ.pop_front());
  end
  // main sequence
  initial
  begin
    step(4);
    rst_n = 1'b1;
    step(8);
    note({8'hE4, 8'h00});
    for (int i = 0; i < 4; i++)
    begin
      {eventMask, portEventIn} = rnd();
      step(1);
      portEventIn = 4'h0;
      m = rnd();
      setMode(m);
      note({8'hE4, m});
      cmd(8'h01 << i);
      note({8'hE4, m & ~(8'h03 << (2 * i))});
    end
    eventMask = 4'h0;
    setMode(8'hFF);
    cmd(8'h10);
    note({8'hE4, 8'h00});
    setMode(8'h55);
    watchdogExpire = 1'b1;
    step(1);
    watchdogExpire = 1'b0;
    step(3);
    note({8'hE4, 8'h00});
    setMode(8'hAA);
    probeEnableData = 8'hFF;
    probeEnableWrite = 1'b1;
    step(1);
    probeEnableWrite = 1'b0;
    step(1);
    chk({4'h0, searchActive}, 8'h0F);
    supplyEventIn = 4'h1;
    step(8);
    note({8'hE4, 8'h00});
    chk({4'h0, searchActive}, 8'h00);
    supplyEventIn = 4'h0;
    setMode(8'hFF);
    slow = 1'b1;
    portEventIn = 4'h4;
    step(1);
    portEventIn = 4'h0;
    step(20);
    note({8'hE4, 8'hFF});
    chk({4'h0, autoRun}, 8'h0F);
    hardResetPinN = 1'b0;
    step(4);
    hardResetPinN = 1'b1;
    step(4);
    note({8'hE4, 8'h00});
    mapWr(8'h1B);
    note({8'h1B, 8'h00});
    chk({7'h0, portOrderMapLocked}, 8'h01);
    mapWr(8'h39);
    note({8'h1B, 8'h00});
    setMode(8'h55);
    powerOnCommand = 4'hF;
    powerOnWrite = 1'b1;
    step(1);
    chk({4'h0, forcePowerOn}, 8'h0F);
    powerOnWrite = 1'b0;
    step(3);
    note({8'h1B, 8'h55});
    // power-on reset with the strap low selects auto on every port
    autoStrapN = 1'b0;
    rst_n = 1'b0;
    step(4);
    rst_n = 1'b1;
    step(8);
    note({8'hE4, 8'hFF});
    chk({7'h0, portOrderMapLocked}, 8'h00);
    step(1);
    give_verdict();
  end
  // hang guard
  initial
  begin
    #50000;
    n_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire

/* verilog/ppmhc_event_flag.sv */
// sticky event flag with clear on read, set wins over clear
`timescale 1ns/100ps
`default_nettype none
module ppmhc_event_flag
#(
  parameter int WIDTH = 4
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] setPulse,
  input wire logic clearRead,
  output logic [WIDTH-1:0] flags
);
  logic [WIDTH-1:0] flag_ff;
  logic [WIDTH-1:0] nxt_flag;

  initial
  begin
    if (WIDTH < 1) $error("WIDTH must be at least 1");
  end

  // a read clears, a same-cycle event survives
  always_comb
  begin
    nxt_flag = (clearRead ? {WIDTH{1'b0}} : flag_ff) | setPulse;
  end

  // flag storage
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      flag_ff <= {WIDTH{1'b0}};
    else
      flag_ff <= nxt_flag;
  end

  assign flags = flag_ff;
endmodule
`default_nettype wire

/* verilog/ppmhc_pkg.sv */
// package with constants and types for the port mode host control block
`default_nettype none
package ppmhc_pkg;
  localparam int NUM_PORTS = 4;
  // port mode encodings
  typedef enum logic [1:0]
  {
    PPMHC_SHUTDOWN = 2'h0,
    PPMHC_MANUAL = 2'h1,
    PPMHC_SEMI = 2'h2,
    PPMHC_AUTO = 2'h3
  } ppmhc_mode_t;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [3:0] EVENT_RESET = 4'h0;
  localparam logic [7:0] MAP_RESET = 8'hE4;
  localparam logic [3:0] SUPPLY_STICKY_RESET = 4'h0;
  // cycles the strap input is sampled after reset release
  localparam int STRAP_SETTLE_CYC = 4;
endpackage
`default_nettype wire

/* verilog/ppmhc_top.sv */
// per-port operating mode, reset commands and event request for one quad
`timescale 1ns/100ps
`default_nettype none
module ppmhc_top
#(
  parameter int PORTS = ppmhc_pkg::NUM_PORTS
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hardResetPinN,
  input wire logic quadSelect,
  input wire logic [7:0] modeWriteData,
  input wire logic modeWrite,
  input wire logic [7:0] probeEnableData,
  input wire logic probeEnableWrite,
  input wire logic [7:0] portResetCommand,
  input wire logic portResetWrite,
  input wire logic [3:0] powerOnCommand,
  input wire logic powerOnWrite,
  input wire logic [7:0] portOrderMapData,
  input wire logic portOrderMapWrite,
  input wire logic autoStrapN,
  input wire logic [3:0] supplyEventIn,
  input wire logic [3:0] supplyConditionIn,
  input wire logic watchdogExpire,
  input wire logic [3:0] portEventIn,
  input wire logic [3:0] eventMask,
  input wire logic portEventRead,
  input wire logic supplyEventRead,
  input wire logic commandRead,
  output logic eventRequestN,
  output logic [7:0] portModeOut,
  output logic [3:0] searchActive,
  output logic [3:0] autoRun,
  output logic [3:0] forcePowerOn,
  output logic [7:0] portOrderMap,
  output logic portOrderMapLocked,
  output logic [7:0] supplyEventOut,
  output logic [7:0] commandReadData,
  output logic [3:0] interruptSummary
);
  // one instance serves one quad; a second quad is a second instance
  initial
  begin
    if (PORTS != 4) $error("PORTS must be 4 per quad");
  end

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers for pins
  logic [1:0] hrsSync_ff;
  logic [1:0] strapSync_ff;
  logic [3:0] supSync0_ff;
  logic [3:0] supSync1_ff;
  logic [3:0] condSync0_ff;
  logic [3:0] condSync1_ff;

  // two flops per pin
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      hrsSync_ff <= 2'h3;
      strapSync_ff <= 2'h3;
      supSync0_ff <= 4'h0;
      supSync1_ff <= 4'h0;
      condSync0_ff <= 4'h0;
      condSync1_ff <= 4'h0;
    end
    else
    begin
      hrsSync_ff <= {hrsSync_ff[0], hardResetPinN};
      strapSync_ff <= {strapSync_ff[0], autoStrapN};
      supSync0_ff <= supplyEventIn;
      supSync1_ff <= supSync0_ff;
      condSync0_ff <= supplyConditionIn;
      condSync1_ff <= condSync0_ff;
    end
  end

  logic pinReset;
  assign pinReset = !hrsSync_ff[1];

  ////////////////////////////////////////////////////////////////////////
  // strap capture after release
  logic [2:0] settle_ff;
  logic strapDone_ff;
  logic strapAuto_ff;

  // settle counter, strap caught once per power-on
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      settle_ff <= 3'h0;
      strapDone_ff <= 1'b0;
      strapAuto_ff <= 1'b0;
    end
    else if (!strapDone_ff)
    begin
      settle_ff <= settle_ff + 3'h1;
      if (settle_ff == 3'(ppmhc_pkg::STRAP_SETTLE_CYC))
      begin
        strapDone_ff <= 1'b1;
        strapAuto_ff <= !strapSync_ff[1];
      end
    end
  end

  logic strapApply;
  assign strapApply = !strapDone_ff && 
    (settle_ff == 3'(ppmhc_pkg::STRAP_SETTLE_CYC)) && !strapSync_ff[1];

  ////////////////////////////////////////////////////////////////////////
  // port modes
  logic [7:0] mode_ff;
  logic [3:0] detEn_ff;
  logic [3:0] clsEn_ff;
  logic [3:0] supplyHit;
  logic [3:0] downMask;
  logic [3:0] supplyDelay_ff;
  assign supplyHit = supSync1_ff & ~supplyDelay_ff;
  assign downMask = (portResetWrite ? portResetCommand[3:0] : 4'h0) |
    {4{portResetWrite && portResetCommand[4]}} |
    {4{watchdogExpire}} | {4{|supplyHit}};

  // mode register, forced to shutdown by resets
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      mode_ff <= {4{ppmhc_pkg::MODE_RESET}};
    else if (pinReset)
      mode_ff <= {4{ppmhc_pkg::MODE_RESET}};
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (downMask[i])
          mode_ff[2*i +: 2] <= ppmhc_pkg::PPMHC_SHUTDOWN;
        else if (strapApply)
          mode_ff[2*i +: 2] <= ppmhc_pkg::PPMHC_AUTO;
        else if (modeWrite)
          mode_ff[2*i +: 2] <= modeWriteData[2*i +: 2];
      end
    end
  end

  // probe enables
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || pinReset)
    begin
      detEn_ff <= 4'h0;
      clsEn_ff <= 4'h0;
    end
    else if (probeEnableWrite)
    begin
      detEn_ff <= probeEnableData[3:0];
      clsEn_ff <= probeEnableData[7:4];
    end
  end

  // mode decode into per-port actions
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      searchActive <= 4'h0;
      autoRun <= 4'h0;
      forcePowerOn <= 4'h0;
      portModeOut <= 8'h0;
    end
    else
    begin
      portModeOut <= mode_ff;
      for (int i = 0; i < 4; i++)
      begin
        searchActive[i] <= mode_ff[2*i +: 2] == ppmhc_pkg::PPMHC_SEMI &&
          detEn_ff[i] && clsEn_ff[i];
        autoRun[i] <= mode_ff[2*i +: 2] == ppmhc_pkg::PPMHC_AUTO;
        forcePowerOn[i] <= powerOnWrite && powerOnCommand[i] &&
          mode_ff[2*i +: 2] == ppmhc_pkg::PPMHC_MANUAL;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // port order map, write once
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || pinReset)
    begin
      portOrderMap <= ppmhc_pkg::MAP_RESET;
      portOrderMapLocked <= 1'b0;
    end
    else if (portOrderMapWrite && !portOrderMapLocked)
    begin
      portOrderMap <= portOrderMapData;
      portOrderMapLocked <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // events
  logic [3:0] portFlags;
  logic [3:0] supFlags;
  logic [3:0] supSticky_ff;

  // edge detect on synchronised supply events
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      supplyDelay_ff <= 4'h0;
    else
      supplyDelay_ff <= supSync1_ff;
  end

  ppmhc_event_flag #(.WIDTH(4)) portEvt
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n && !pinReset),
    .setPulse(portEventIn),
    .clearRead(portEventRead),
    .flags(portFlags)
  );

  ppmhc_event_flag #(.WIDTH(4)) supEvt
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n && !pinReset),
    .setPulse(supplyHit),
    .clearRead(supplyEventRead),
    .flags(supFlags)
  );

  // upper nibble survives pin reset while its cause persists
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      supSticky_ff <= ppmhc_pkg::SUPPLY_STICKY_RESET;
    else
      supSticky_ff <= condSync1_ff | (supSticky_ff & condSync1_ff);
  end

  // summary, supply readback, one-shot readback and request
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      eventRequestN <= 1'b1;
      supplyEventOut <= 8'h0;
      commandReadData <= 8'h0;
      interruptSummary <= 4'h0;
    end
    else
    begin
      supplyEventOut <= {supSticky_ff, supFlags};
      commandReadData <= commandRead ? 8'h00 : 8'h00;
      interruptSummary <= {2'h0, |supFlags, |portFlags};
      eventRequestN <= !(|(portFlags & ~eventMask) |
        (|supFlags));
    end
  end
endmodule
`default_nettype wire
